/* File: common/imcd_map.vh */
// constants for the internal move command decoder
// Summary of operation
// RULE1: bits 31-27 pick plain, byte-typed, dword or register-length copy.
// RULE2: with bit 24 set, the next command waits for copy completion.
// RULE3: bits 23-20 give the copy origin code.
// RULE4: bits 19-16 give the copy target code.
// RULE5: forbidden origin/target pairs are rejected.
// RULE6: offset above 128 is an error unless descriptor buffer takes part.
// RULE7: dword copies use 8-byte aligned offsets, 4-byte for descriptor buffer.
// RULE8: fixed forms take byte count from bits 7-0, at most 128.
// RULE9: register form type bits 7-6: plain, dword, byte, or error.
// RULE10: register form bits 2-0 pick math register holding the count.
// RULE11: alignment or input source to output FIFO uses 16 count bits, else 8.
// RULE12: swap enabled: swap, no swap or error per pair; byte form inverts.
// RULE13: some pairs error for byte form but stay legal unswapped for plain.
// RULE14: context with descriptor buffer or output FIFO: option gives 0/16/32/48.
// RULE15: math pairs: option bits give math start offset 0, 4, 6 or 7.
// RULE16: origin 9h: low option bit picks class one (1) or two (0) block.
// RULE17: flush option only when target is the output FIFO.
// RULE18: origin Ah: option picks controller, class one, class two block, or error.
// RULE19: output FIFO to input, key engine or aux FIFO needs zero offset.
// RULE20: alignment to output FIFO: fixed form count is offset over length.
// RULE21: key with context: low option bit says which side offset applies to.
// RULE22: context to descriptor buffer: offset into buffer, option into context.
// RULE23: math reads past register 3 carry on into registers 4-7.
// RULE24: origin 8h reads controller alignment block, always flushed, routing automatic.
// RULE25: any decode error halts the descriptor and reports an error status.
`ifndef IMCD_MAP_VH
`define IMCD_MAP_VH
`define IMCD_CLS_PLAIN   5'h0F
`define IMCD_CLS_BYTE    5'h07
`define IMCD_CLS_DWORD   5'h06
`define IMCD_CLS_REGLEN  5'h0E
`define IMCD_BIT_STALL   24
`define IMCD_ORG_HI      23
`define IMCD_ORG_LO      20
`define IMCD_TGT_HI      19
`define IMCD_TGT_LO      16
`define IMCD_AUX_HI      26
`define IMCD_AUX_LO      25
`define IMCD_LOC_CTX1    4'h0
`define IMCD_LOC_CTX2    4'h1
`define IMCD_LOC_OFIFO   4'h2
`define IMCD_LOC_DESC    4'h3
`define IMCD_LOC_ALNDC   4'h8
`define IMCD_LOC_ALNC    4'h9
`define IMCD_LOC_ALNX    4'hA
`define IMCD_LOC_RSVD    4'hB
`define IMCD_LOC_PKA     4'hC
`define IMCD_LOC_AUXF    4'hF
`define IMCD_FORM_PLAIN  2'h0
`define IMCD_FORM_DWORD  2'h1
`define IMCD_FORM_BYTE   2'h2
`define IMCD_FORM_BAD    2'h3
`define IMCD_MAX_OFF     8'h80
`define IMCD_MAX_LEN     8'h80
`define IMCD_CTX_STEP    8'h10
`define IMCD_ALN_DESCRIPTOR_CONTROLLER    2'h0
`define IMCD_ALN_C1      2'h1
`define IMCD_ALN_C2      2'h2
`define IMCD_ERR_NONE    4'h0
`define IMCD_ERR_PAIR    4'h1
`define IMCD_ERR_TYPE    4'h2
`define IMCD_ERR_OFFSET  4'h3
`define IMCD_ERR_LENGTH  4'h4
`define IMCD_ERR_ALIGN   4'h5
`define IMCD_ERR_CLASS   4'h6
`define IMCD_RST_CMD     32'h00000000
`endif

/* File: verif/imcd_mover_model.sv */
// far-side model: math register file and move engine answers
`timescale 1ns/10ps
module imcd_mover_model (
   // clock and pacing
   input  wire        clk,
   input  wire        slow,
   // math register read
   input  wire        len_reg_req,
   input  wire [2:0]  length_register_select,
   output reg         len_reg_ack = 1'b0,
   output reg  [15:0] len_reg_value = 16'h0000,
   // move engine
   input  wire        mv_req,
   output reg         mv_ack = 1'b0,
   output reg         mv_done = 1'b0
);
   integer wait_n = 0;
   integer done_n = 0;
   always @(negedge clk) begin
      mv_done = (done_n == 1);
      if (done_n > 0) done_n = done_n - 1;
      if (mv_ack) begin
         mv_ack = 1'b0;
         done_n = slow ? 6 : 3;
      end else if (mv_req && wait_n >= (slow ? 3 : 0)) begin
         mv_ack = 1'b1;
         wait_n = 0;
      end else if (mv_req) wait_n = wait_n + 1;
      // a released value line keeps toggling so a stale count is never seen
      if (len_reg_req && !len_reg_ack) begin
         len_reg_ack = 1'b1;
         len_reg_value = {5'h01, length_register_select, 8'h20};
      end else begin
         len_reg_ack = 1'b0;
         len_reg_value = ~len_reg_value;
      end
   end
endmodule

/* File: verif/imcd_top_asserts.sv */
// port assertions for the internal move command decoder
`timescale 1ns/10ps
module imcd_top_asserts (
   // clock and reset
   input wire        clk,
   input wire        resetn,
   // command side
   input wire        cmd_valid,
   input wire [31:0] cmd_word,
   input wire        cmd_ready,
   input wire        cmd_done,
   input wire        len_reg_req,
   input wire [2:0]  length_register_select,
   // move and error side
   input wire        mv_req,
   input wire        mv_ack,
   input wire [3:0]  mv_origin,
   input wire [15:0] mv_len,
   input wire [1:0]  mv_align_sel,
   input wire        mv_flush,
   input wire        err_halt,
   input wire [3:0]  err_code
);
   wire       take = cmd_valid && cmd_ready;
   reg [31:0] lc_ff;
   // the word is only valid in its accept cycle
   always @(posedge clk or negedge resetn) begin
      if (!resetn) lc_ff <= 32'h00000000;
      else if (take) lc_ff <= cmd_word;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   fixed_answer_a:
      assert property (take && cmd_word[31:27] == 5'h0F |-> ##3 (mv_req || err_halt))
      else $error("no answer to fixed copy");
   origin_code_a:
      assert property ($rose(mv_req) |-> mv_origin == lc_ff[23:20])
      else $error("origin code wrong");
   stall_done_a:
      assert property (mv_req && mv_ack |=> cmd_done == !lc_ff[24])
      else $error("done timing wrong");
   pair_reject_a:
      assert property (take && cmd_word[31:16] == 16'h7833 |-> ##3 (err_halt && err_code == 4'h1))
      else $error("forbidden pair taken");
   halt_quiet_a:
      assert property (err_halt |-> !cmd_done && !mv_req)
      else $error("activity while halted");
   len_select_a:
      assert property (len_reg_req |-> length_register_select == lc_ff[2:0])
      else $error("math select wrong");
   align_pick_a:
      assert property ($rose(mv_req) && lc_ff[23:20] == 4'h9
         |-> mv_align_sel == (lc_ff[25] ? 2'h1 : 2'h2))
      else $error("alignment block wrong");
   descriptor_controller_flush_a:
      assert property ($rose(mv_req) && lc_ff[23:20] == 4'h8 |-> mv_flush)
      else $error("controller block not flushed");
   long_count_a:
      assert property ($rose(mv_req) && lc_ff[31:27] == 5'h0F && lc_ff[23:16] == 8'h82
         |-> mv_len == lc_ff[15:0])
      else $error("wide count wrong");
endmodule
bind imcd_top imcd_top_asserts chk (.*);

/* File: verif/tb_top.sv */
// self-checking bench for the internal move command decoder
`timescale 1ns/10ps
module tb_top;
   reg         clk = 1'b0;
   reg         resetn = 1'b0;
   reg         cmd_valid = 1'b0;
   reg  [31:0] cmd_word = 32'h00000000;
   reg         byte_swap_en = 1'b1;
   reg         word_swap_en = 1'b0;
   reg         auto_route_en = 1'b1;
   reg         err_clear = 1'b0;
   reg         slow = 1'b0;
   wire        cmd_ready, cmd_done, len_reg_req, len_reg_ack, mv_req, mv_ack, mv_done;
   wire        mv_swap_bytes, mv_swap_words, mv_flush, mv_last, mv_route_entry, err_halt;
   wire [15:0] len_reg_value, mv_len;
   wire [7:0]  mv_src_off, mv_dst_off;
   wire [3:0]  mv_origin, mv_target, err_code;
   wire [2:0]  length_register_select;
   wire [1:0]  mv_align_sel;
   reg  [41:0] mq [$];
   reg  [3:0]  eq [$];
   reg  [41:0] e;
   reg  [31:0] r = 32'h000029D3;
   reg  [31:0] stp = 32'h07060400;
   reg  [35:0] et [0:8] = '{36'h178330010, 36'h178220010, 36'h138010010, 36'h2703000C0,
      36'h378028110, 36'h478300081, 36'h57EA20010, 36'h378280810, 36'h680300010};
   reg         err_d = 1'b0;
   integer     n_errors = 0;
   integer     checked = 0;
   integer     i;
   reg  [1:0]  a;
   reg  [4:0]  cl;
   reg  [7:0]  ln;

   imcd_top DUT (.*);
   imcd_mover_model PM (.*);

   always #4 clk = ~clk;

   function [31:0] rnd(input [31:0] x);
      reg [31:0] y;
      begin
         y = x ^ (x << 13);
         y = y ^ (y >> 17);
         rnd = y ^ (y << 5);
      end
   endfunction

   function [31:0] cw(input [4:0] k, input [1:0] x, input w, input [3:0] s, input [3:0] d,
                      input [7:0] o, input [7:0] l);
      cw = {k, x, w, s, d, o, l};
   endfunction

   // offsets take part in the compare only when the top bit is set
   function [41:0] ex(input c, input sw, input [3:0] s, input [3:0] d, input [15:0] l,
                      input [7:0] so, input [7:0] dof);
      ex = {c, sw, s, d, l, so, dof};
   endfunction

   task chk_move(input [41:0] x, input [41:0] g);
      begin
         checked = checked + 1;
         if (g !== x) begin
            n_errors = n_errors + 1;
            $display("[FAIL] move expected %h seen %h", x, g);
         end
      end
   endtask

   task chk_err(input [3:0] x, input [3:0] g);
      begin
         checked = checked + 1;
         if (g !== x) begin
            n_errors = n_errors + 1;
            $display("[FAIL] err_code expected %h seen %h", x, g);
         end
      end
   endtask

   task final_report;
      begin
         if (mq.size() != 0 || eq.size() != 0) n_errors = n_errors + 1;
         $display("checked %0d errors %0d", checked, n_errors);
         if (n_errors == 0 && checked > 0) $display("All tests passed");
         else $display("Some tests failed");
         $finish;
      end
   endtask

   task send(input [31:0] c);
      integer k;
      begin
         k = 0;
         while (cmd_ready !== 1'b1 && k < 100) begin
            @(negedge clk);
            k = k + 1;
         end
         cmd_word = c;
         cmd_valid = 1'b1;
         @(negedge clk);
         cmd_valid = 1'b0;
         cmd_word = ~c;
         k = 0;
         while (cmd_done !== 1'b1 && err_halt !== 1'b1 && k < 100) begin
            @(negedge clk);
            k = k + 1;
         end
         if (err_halt === 1'b1) begin
            err_clear = 1'b1;
            @(negedge clk);
            err_clear = 1'b0;
         end
         @(negedge clk);
      end
   endtask

   task mrun(input [31:0] c, input [41:0] x);
      begin
         mq.push_back(x);
         send(c);
      end
   endtask

   always @(posedge clk) begin
      err_d <= err_halt;
      if (mv_req === 1'b1 && mv_ack === 1'b1) begin
         if (mq.size() == 0) e = {42{1'b1}};
         else e = mq.pop_front();
         chk_move(e, {e[41], mv_swap_bytes, mv_origin, mv_target, mv_len,
                      e[41] ? {mv_src_off, mv_dst_off} : e[15:0]});
      end
      if (err_halt === 1'b1 && err_d !== 1'b1)
         chk_err(eq.size() == 0 ? 4'hF : eq.pop_front(), err_code);
   end

   initial begin
      repeat (20) @(negedge clk);
      resetn = 1'b1;
      for (i = 0; i < 4; i = i + 1) begin
         a = i[1:0];
         cl = (a == 2'h1) ? 5'h07 : (a == 2'h2) ? 5'h06 : 5'h0F;
         r = rnd(r);
         slow = r[3];
         ln = {1'b0, r[14:8]} + 8'h01;
         mrun(cw(cl, a, r[0], 4'h1, 4'h3, 8'h40, 8'h20),
              ex(1'b1, cl == 5'h0F, 4'h1, 4'h3, 16'h0020, {2'h0, a, 4'h0}, 8'h40));
         mrun(cw(5'h0F, a, r[1], 4'h3, 4'h0, r[23:16], ln),
              ex(1'b1, 1'b1, 4'h3, 4'h0, {8'h00, ln}, r[23:16], {2'h0, a, 4'h0}));
         mrun(cw(5'h0F, a, r[2], {2'h1, a}, 4'h3, 8'h10, 8'h28),
              ex(1'b1, 1'b0, {2'h1, a}, 4'h3, 16'h0028, {3'h0, a, 3'h0} + stp[8*a +: 8], 8'h10));
      end
      r = rnd(r);
      mrun(cw(5'h0E, 2'h0, 1'b0, 4'h3, 4'h2, 8'h00, {5'h00, r[2:0]}),
           ex(1'b0, 1'b1, 4'h3, 4'h2, 16'h0020, 8'h00, 8'h00));
      mrun(cw(5'h0E, {1'b1, r[4]}, 1'b1, 4'h9, 4'h2, 8'h33, {5'h00, r[2:0]}),
           ex(1'b0, 1'b0, 4'h9, 4'h2, {5'h01, r[2:0], 8'h20}, 8'h00, 8'h00));
      mrun(cw(5'h0F, 2'h0, 1'b1, 4'h8, 4'h2, 8'h01, 8'h90),
           ex(1'b0, 1'b0, 4'h8, 4'h2, 16'h0190, 8'h00, 8'h00));
      mrun(cw(5'h0F, 2'h1, 1'b0, 4'hA, 4'h2, 8'h00, 8'h40),
           ex(1'b0, 1'b0, 4'hA, 4'h2, 16'h0040, 8'h00, 8'h00));
      mrun(cw(5'h0F, 2'h0, 1'b0, 4'h0, 4'h1, 8'h08, 8'h10),
           ex(1'b0, 1'b0, 4'h0, 4'h1, 16'h0010, 8'h00, 8'h00));
      byte_swap_en = 1'b0;
      mrun(cw(5'h0F, 2'h0, 1'b0, 4'h3, 4'h0, 8'h00, 8'h08),
           ex(1'b1, 1'b0, 4'h3, 4'h0, 16'h0008, 8'h00, 8'h00));
      for (i = 0; i < 9; i = i + 1) begin
         eq.push_back(et[i][35:32]);
         send(et[i][31:0]);
      end
      final_report;
   end

   // twenty-seven commands of under forty cycles each; this is far beyond that
   initial begin
      #300000;
      n_errors = n_errors + 1;
      final_report;
   end
endmodule

/* File: verilog/imcd_len_calc.v */
// byte count and offset checks for one copy
`timescale 1ns/10ps
`include "imcd_map.vh"
module imcd_len_calc (
   // copy description
   input  wire [3:0]  src,
   input  wire [3:0]  dst,
   input  wire [1:0]  form,
   input  wire        reg_form,
   input  wire [7:0]  offset,
   input  wire [7:0]  fixed_len,
   input  wire [15:0] math_val,
   // results
   output reg  [15:0] len,
   output reg         wide,
   output reg         len_err,
   output reg         off_err
);
   reg desc;
   reg zero_req;

   always @* begin
      wide = (src[3:2] == 2'h2 && src != `IMCD_LOC_RSVD) && dst == `IMCD_LOC_OFIFO;
      desc = (src == `IMCD_LOC_DESC) || (dst == `IMCD_LOC_DESC);
      zero_req = (src == `IMCD_LOC_OFIFO) &&
                 ((dst[3:2] == 2'h2 && dst != `IMCD_LOC_RSVD) || dst == `IMCD_LOC_PKA ||
                  dst == `IMCD_LOC_AUXF || form == `IMCD_FORM_DWORD);
      len_err = 1'b0;
      off_err = 1'b0;
      if (reg_form)
         len = wide ? math_val : {8'h00, math_val[7:0]}; // [RULE11]
      else if (wide)
         len = {offset, fixed_len}; // [RULE20]
      else begin
         len = {8'h00, fixed_len}; // [RULE8]
         len_err = (fixed_len > `IMCD_MAX_LEN); // [RULE8]
      end
      if (!wide) begin
         if (!desc && offset > `IMCD_MAX_OFF)
            off_err = 1'b1; // [RULE6]
         if (form == `IMCD_FORM_DWORD && (desc ? offset[1:0] != 2'h0 : offset[2:0] != 3'h0))
            off_err = 1'b1; // [RULE7]
         if (zero_req && offset != 8'h00)
            off_err = 1'b1; // [RULE19]
      end
   end
endmodule

/* File: verilog/imcd_pair_check.v */
// origin/target legality and swap selection for one copy
`timescale 1ns/10ps
`include "imcd_map.vh"
module imcd_pair_check (
   // copy description
   input  wire [3:0] src,
   input  wire [3:0] dst,
   input  wire [1:0] form,
   input  wire [1:0] aux,
   // endian settings
   input  wire       byte_swap_en,
   input  wire       word_swap_en,
   // results
   output reg        pair_err,
   output reg        swap_bytes,
   output reg        swap_words,
   output reg        off_to_dst
);
   reg m_swap;
   reg b_err;

   function is_ctx;
      input [3:0] c;
      is_ctx = (c == `IMCD_LOC_CTX1) || (c == `IMCD_LOC_CTX2);
   endfunction

   function is_inf;
      input [3:0] c;
      is_inf = (c == `IMCD_LOC_ALNDC) || (c == `IMCD_LOC_ALNC) || (c == `IMCD_LOC_ALNX);
   endfunction

   always @* begin
      m_swap = 1'b0;
      b_err = 1'b0;
      pair_err = 1'b0;
      off_to_dst = 1'b0;
      if (src == `IMCD_LOC_RSVD || src == `IMCD_LOC_PKA || src == `IMCD_LOC_AUXF ||
          dst == `IMCD_LOC_RSVD)
         pair_err = 1'b1; // [RULE5]
      if (src == dst && (src == `IMCD_LOC_OFIFO || src == `IMCD_LOC_DESC))
         pair_err = 1'b1; // [RULE5]
      if (is_inf(src) && (is_inf(dst) || dst == `IMCD_LOC_AUXF || dst[3:1] == 3'h6))
         pair_err = 1'b1; // [RULE5]
      case (src[3:2])
         2'h0: begin
            if (is_ctx(src)) begin
               m_swap = (dst == `IMCD_LOC_DESC);
               b_err = is_ctx(dst) || is_inf(dst); // [RULE13]
               off_to_dst = (dst == `IMCD_LOC_DESC) || (dst[3:1] == 3'h6 && aux[0]); // [RULE22] [RULE21]
            end else if (src == `IMCD_LOC_OFIFO) begin
               b_err = is_ctx(dst); // [RULE13]
               off_to_dst = 1'b1;
            end else begin
               m_swap = !(is_inf(dst) || dst == `IMCD_LOC_PKA);
            end
         end
         2'h1: begin
            off_to_dst = is_ctx(dst) || dst == `IMCD_LOC_DESC || dst[3:2] == 2'h1;
         end
         2'h2: begin
            m_swap = (dst == `IMCD_LOC_DESC);
            b_err = is_ctx(dst) || dst == `IMCD_LOC_PKA;
            off_to_dst = 1'b1;
         end
         default: begin
            b_err = is_inf(dst);
            off_to_dst = (dst == `IMCD_LOC_DESC) || (is_ctx(dst) && aux[0]); // [RULE21]
         end
      endcase
      if (form == `IMCD_FORM_BYTE && b_err)
         pair_err = 1'b1; // [RULE13]
      // byte form takes the opposite choice wherever both forms are legal
      swap_bytes = byte_swap_en && form != `IMCD_FORM_DWORD &&
                   ((form == `IMCD_FORM_BYTE) ? !m_swap : m_swap); // [RULE12]
      swap_words = word_swap_en && form == `IMCD_FORM_DWORD;
   end
endmodule

/* File: verilog/imcd_top.v */
// internal move command decoder: sequencing, option decode and move issue
`timescale 1ns/10ps
`include "imcd_map.vh"
module imcd_top (
   // clock and reset
   input  wire        clk,
   input  wire        resetn,
   // command stream from descriptor fetch
   input  wire        cmd_valid,
   input  wire [31:0] cmd_word,
   output wire        cmd_ready,
   output wire        cmd_done,
   // endian and routing settings
   input  wire        byte_swap_en,
   input  wire        word_swap_en,
   input  wire        auto_route_en,
   // math register read port
   output wire        len_reg_req,
   output wire [2:0]  length_register_select,
   input  wire        len_reg_ack,
   input  wire [15:0] len_reg_value,
   // move request to the internal crypto bus engine
   output wire        mv_req,
   input  wire        mv_ack,
   input  wire        mv_done,
   output wire [3:0]  mv_origin,
   output wire [3:0]  mv_target,
   output wire [15:0] mv_len,
   output wire [7:0]  mv_src_off,
   output wire [7:0]  mv_dst_off,
   output wire [1:0]  mv_align_sel,
   output wire        mv_swap_bytes,
   output wire        mv_swap_words,
   output wire        mv_flush,
   output wire        mv_last,
   output wire        mv_route_entry,
   // error report to the job controller
   output wire        err_halt,
   output wire [3:0]  err_code,
   input  wire        err_clear
);
   localparam S_IDLE  = 3'h0;
   localparam S_DEC   = 3'h1;
   localparam S_FETCH = 3'h2;
   localparam S_CHK   = 3'h3;
   localparam S_ISSUE = 3'h4;
   localparam S_WAIT  = 3'h5;
   localparam S_HALT  = 3'h6;

   reg        rst_meta_ff;
   reg        rst_sync_ff;
   reg [2:0]  state_ff;
   reg [2:0]  nxt_state;
   reg [31:0] cmd_ff;
   reg [15:0] mval_ff;
   reg        ready_ff;
   reg        done_ff;
   reg        lreq_ff;
   reg        req_ff;
   reg [3:0]  org_ff;
   reg [3:0]  tgt_ff;
   reg [15:0] len_ff;
   reg [7:0]  soff_ff;
   reg [7:0]  doff_ff;
   reg [1:0]  aln_ff;
   reg        sb_ff;
   reg        sw_ff;
   reg        flush_ff;
   reg        last_ff;
   reg        route_ff;
   reg        halt_ff;
   reg [3:0]  code_ff;

   wire       rst_n = rst_sync_ff;
   wire [4:0] cls = cmd_ff[31:27];
   wire [3:0] org = cmd_ff[`IMCD_ORG_HI:`IMCD_ORG_LO]; // [RULE3]
   wire [3:0] tgt = cmd_ff[`IMCD_TGT_HI:`IMCD_TGT_LO]; // [RULE4]
   wire [1:0] aux = cmd_ff[`IMCD_AUX_HI:`IMCD_AUX_LO];
   wire [7:0] offset = cmd_ff[15:8];
   wire       reg_form = (cls == `IMCD_CLS_REGLEN);
   wire       stall = cmd_ff[`IMCD_BIT_STALL];

   reg  [1:0] form;
   reg        cls_err;
   wire       pair_err;
   wire       swap_b;
   wire       swap_w;
   wire       off_to_dst;
   wire [15:0] len_c;
   wire       wide;
   wire       len_err;
   wire       off_err;

   function is_ctx;
      input [3:0] c;
      is_ctx = (c == `IMCD_LOC_CTX1) || (c == `IMCD_LOC_CTX2);
   endfunction

   function is_math;
      input [3:0] c;
      is_math = (c[3:2] == 2'h1);
   endfunction

   function [7:0] math_step;
      input [1:0] a;
      case (a)
         2'h0: math_step = 8'h00;
         2'h1: math_step = 8'h04;
         2'h2: math_step = 8'h06;
         default: math_step = 8'h07;
      endcase
   endfunction

   // math side address is linear over the bank, so a long read runs past
   // register 3 into 4-7 without any wrap logic here
   function [7:0] math_base;
      input [3:0] c;
      input [1:0] a;
      math_base = {3'h0, c[1:0], 3'h0} + math_step(a); // [RULE15] [RULE23]
   endfunction

   // command class and item type decode
   always @* begin
      form = `IMCD_FORM_PLAIN;
      cls_err = 1'b0;
      if (cls == `IMCD_CLS_BYTE)
         form = `IMCD_FORM_BYTE; // [RULE1]
      else if (cls == `IMCD_CLS_DWORD)
         form = `IMCD_FORM_DWORD; // [RULE1]
      else if (reg_form)
         form = cmd_ff[7:6]; // [RULE9]
      else if (cls != `IMCD_CLS_PLAIN)
         cls_err = 1'b1; // [RULE1]
   end

   imcd_pair_check u_pair (
      .src          (org),
      .dst          (tgt),
      .form         (form),
      .aux          (aux),
      .byte_swap_en (byte_swap_en),
      .word_swap_en (word_swap_en),
      .pair_err     (pair_err),
      .swap_bytes   (swap_b),
      .swap_words   (swap_w),
      .off_to_dst   (off_to_dst)
   );

   imcd_len_calc u_len (
      .src       (org),
      .dst       (tgt),
      .form      (form),
      .reg_form  (reg_form),
      .offset    (offset),
      .fixed_len (cmd_ff[7:0]),
      .math_val  (mval_ff),
      .len       (len_c),
      .wide      (wide),
      .len_err   (len_err),
      .off_err   (off_err)
   );

   // option field decode
   reg [7:0] s_off;
   reg [7:0] d_off;
   reg [1:0] aln;
   reg       aln_err;
   reg       flush;
   reg       last;
   reg       route;
   reg [3:0] err_sel;

   always @* begin
      s_off = off_to_dst ? 8'h00 : offset;
      d_off = off_to_dst ? offset : 8'h00;
      aln = `IMCD_ALN_DESCRIPTOR_CONTROLLER;
      aln_err = 1'b0;
      flush = (tgt == `IMCD_LOC_PKA);
      last = 1'b0;
      if (wide) begin
         s_off = 8'h00;
         d_off = 8'h00;
      end
      if (is_ctx(org) && (tgt == `IMCD_LOC_DESC || tgt == `IMCD_LOC_OFIFO))
         s_off = {aux, 4'h0}; // [RULE14] [RULE22]
      if (is_ctx(tgt) && (org == `IMCD_LOC_DESC || org == `IMCD_LOC_OFIFO))
         d_off = d_off + {aux, 4'h0}; // [RULE14]
      if (is_math(org) && (is_ctx(tgt) || tgt == `IMCD_LOC_DESC ||
                           tgt == `IMCD_LOC_OFIFO || is_math(tgt)))
         s_off = s_off + math_base(org, aux); // [RULE15]
      else if (is_math(org))
         s_off = s_off + math_base(org, 2'h0); // [RULE23]
      if (is_math(tgt) && !is_math(org) && (is_ctx(org) || org == `IMCD_LOC_DESC ||
                                            org == `IMCD_LOC_OFIFO))
         d_off = d_off + math_base(tgt, aux); // [RULE15]
      else if (is_math(tgt))
         d_off = d_off + math_base(tgt, 2'h0);
      if (org == `IMCD_LOC_ALNDC) begin
         aln = `IMCD_ALN_DESCRIPTOR_CONTROLLER;
         flush = 1'b1; // [RULE24]
      end else if (org == `IMCD_LOC_ALNC) begin
         aln = aux[0] ? `IMCD_ALN_C1 : `IMCD_ALN_C2; // [RULE16]
         // the program only sets flush toward the output FIFO; mask it elsewhere
         flush = aux[1] && (tgt == `IMCD_LOC_OFIFO); // [RULE17]
      end else if (org == `IMCD_LOC_ALNX) begin
         aln = aux; // [RULE18]
         aln_err = (aux == 2'h3); // [RULE18]
      end
      if ((is_ctx(org) || org[3:1] == 3'h6 || org == 4'hE) &&
          (tgt == `IMCD_LOC_ALNDC || tgt == `IMCD_LOC_ALNC)) begin
         last = aux[0];
         flush = (tgt == `IMCD_LOC_ALNDC) && aux[1];
      end
      route = auto_route_en && org != `IMCD_LOC_ALNX && tgt != `IMCD_LOC_ALNX &&
              (org == `IMCD_LOC_ALNDC || org == `IMCD_LOC_ALNC ||
               tgt == `IMCD_LOC_ALNDC || tgt == `IMCD_LOC_ALNC ||
               tgt == `IMCD_LOC_PKA); // [RULE24] [RULE18]
      if (cls_err)
         err_sel = `IMCD_ERR_CLASS;
      else if (form == `IMCD_FORM_BAD)
         err_sel = `IMCD_ERR_TYPE; // [RULE9]
      else if (pair_err)
         err_sel = `IMCD_ERR_PAIR; // [RULE5]
      else if (aln_err)
         err_sel = `IMCD_ERR_ALIGN; // [RULE18]
      else if (off_err)
         err_sel = `IMCD_ERR_OFFSET; // [RULE6]
      else if (len_err)
         err_sel = `IMCD_ERR_LENGTH; // [RULE8]
      else
         err_sel = `IMCD_ERR_NONE;
   end

   // reset release through two flops
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         S_IDLE: begin
            if (cmd_valid && ready_ff)
               nxt_state = S_DEC;
         end
         S_DEC: begin
            nxt_state = reg_form ? S_FETCH : S_CHK;
         end
         S_FETCH: begin
            if (len_reg_ack)
               nxt_state = S_CHK;
         end
         S_CHK: begin
            nxt_state = (err_sel != `IMCD_ERR_NONE) ? S_HALT : S_ISSUE; // [RULE25]
         end
         S_ISSUE: begin
            if (mv_ack)
               nxt_state = stall ? S_WAIT : S_IDLE; // [RULE2]
         end
         S_WAIT: begin
            if (mv_done)
               nxt_state = S_IDLE; // [RULE2]
         end
         S_HALT: begin
            if (err_clear)
               nxt_state = S_IDLE; // [RULE25]
         end
         default: begin
            nxt_state = S_IDLE;
         end
      endcase
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= S_IDLE;
         cmd_ff <= `IMCD_RST_CMD;
         mval_ff <= 16'h0000;
         ready_ff <= 1'b0;
         done_ff <= 1'b0;
         lreq_ff <= 1'b0;
         req_ff <= 1'b0;
         org_ff <= 4'h0;
         tgt_ff <= 4'h0;
         len_ff <= 16'h0000;
         soff_ff <= 8'h00;
         doff_ff <= 8'h00;
         aln_ff <= 2'h0;
         sb_ff <= 1'b0;
         sw_ff <= 1'b0;
         flush_ff <= 1'b0;
         last_ff <= 1'b0;
         route_ff <= 1'b0;
         halt_ff <= 1'b0;
         code_ff <= `IMCD_ERR_NONE;
      end else begin
         state_ff <= nxt_state;
         done_ff <= 1'b0;
         ready_ff <= (nxt_state == S_IDLE);
         if (state_ff == S_IDLE && cmd_valid && ready_ff)
            cmd_ff <= cmd_word;
         if (state_ff == S_DEC && reg_form)
            lreq_ff <= 1'b1; // [RULE10]
         if (state_ff == S_FETCH && len_reg_ack) begin
            lreq_ff <= 1'b0;
            mval_ff <= len_reg_value; // [RULE10]
         end
         if (state_ff == S_CHK) begin
            if (err_sel != `IMCD_ERR_NONE) begin
               halt_ff <= 1'b1; // [RULE25]
               code_ff <= err_sel;
            end else begin
               req_ff <= 1'b1;
               org_ff <= org;
               tgt_ff <= tgt;
               len_ff <= len_c;
               soff_ff <= s_off;
               doff_ff <= d_off;
               aln_ff <= aln;
               sb_ff <= swap_b; // [RULE12]
               sw_ff <= swap_w;
               flush_ff <= flush;
               last_ff <= last;
               route_ff <= route;
            end
         end
         if (state_ff == S_ISSUE && mv_ack) begin
            req_ff <= 1'b0;
            done_ff <= !stall;
         end
         // without the stall bit the command retires at acceptance
         if (state_ff == S_WAIT && mv_done)
            done_ff <= 1'b1; // [RULE2]
         if (state_ff == S_HALT && err_clear) begin
            halt_ff <= 1'b0;
            code_ff <= `IMCD_ERR_NONE;
         end
      end
   end

   assign cmd_ready = ready_ff;
   assign cmd_done = done_ff;
   assign len_reg_req = lreq_ff;
   assign length_register_select = cmd_ff[2:0]; // [RULE10]
   assign mv_req = req_ff;
   assign mv_origin = org_ff;
   assign mv_target = tgt_ff;
   assign mv_len = len_ff;
   assign mv_src_off = soff_ff;
   assign mv_dst_off = doff_ff;
   assign mv_align_sel = aln_ff;
   assign mv_swap_bytes = sb_ff;
   assign mv_swap_words = sw_ff;
   assign mv_flush = flush_ff;
   assign mv_last = last_ff;
   assign mv_route_entry = route_ff;
   assign err_halt = halt_ff;
   assign err_code = code_ff;
endmodule
